// [src/dpl_pkg.sv]
/*
  Package of the drain-period lubricator scheduler: timing counts, limits,
  menu states and the display bundle.
  Assumes a single 50 MHz system clock shared by every user of the package.
*/
package dpl_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;           // System clock period.
    localparam int TICK_NS = 1_000_000;          // One millisecond tick.
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S = 1000;              // Ticks per second.

    // ------------------------------------------------------------------
    // Drain period limits and interval arithmetic
    // ------------------------------------------------------------------
    localparam logic [5:0] DRAIN_MIN = 6'h01;    // Lowest month value.
    localparam logic [5:0] DRAIN_MAX = 6'h24;    // Highest month value, 36.
    localparam logic [5:0] DRAIN_RESET = 6'h06;  // Default, 6 months.
    localparam logic [15:0] HOURS_PER_MONTH = 16'h02DC;    // 30.5 d * 24 h.
    localparam logic [27:0] SEC_PER_MONTH = 28'h0283540;   // 2635072 s, 128 s short of 732 h * 3600 s.
    localparam logic [27:0] STROKES_SMALL = 28'h000030C;   // 780 strokes.
    localparam logic [27:0] STROKES_LARGE = 28'h0000618;   // 1560 strokes.

    // ------------------------------------------------------------------
    // Burst timing in seconds
    // ------------------------------------------------------------------
    localparam int STROKE_S = 17;                // Longest stroke time.
    localparam int RELAX_S = 2;                  // Relaxation after stroke.

    // ------------------------------------------------------------------
    // Menu timing in milliseconds
    // ------------------------------------------------------------------
    localparam int ENTER_HOLD_MS = 3000;         // Key hold to reach label.
    localparam int FLASH_HALF_MS = 250;          // Half period of a flash.
    localparam int FLASH_PHASES = 4;             // Two on/off flashes.
    localparam int DECIDE_MS = 5000;             // Wait for a change request.
    localparam int REPLACE_GAP_MS = 1000;        // Brief removal window.
    localparam int AUTO_FIRST_MS = 800;          // First auto-advance step.
    localparam int AUTO_MIN_MS = 150;            // Fastest auto-advance step.
    localparam int AUTO_DEC_MS = 50;             // Shortening per step.

    // ------------------------------------------------------------------
    // Menu states, Gray coded along the usual path
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_HOLD = 4'h1,
        ST_LABEL = 4'h3,
        ST_ENTRY_OK = 4'h2,
        ST_SHOW_MODE = 4'h6,
        ST_SHOW_VAL = 4'h7,
        ST_EDIT = 4'h5,
        ST_GAP = 4'h4,
        ST_COMMIT_OK = 4'hC,
        ST_KEEP_OK = 4'hD
    } dpl_state_type;

    // Everything the display shows, moved as one bundle.
    typedef struct packed {
        logic settings_label;                    // Settings label lit.
        logic mode_icon;                         // Active mode shown.
        logic dbl_circle;                        // Key-present symbol.
        logic hook;                              // Confirmation hook.
        logic blank;                             // Flash off phase.
        logic show_pressure;                     // Pressure instead of value.
        logic [5:0] value;                       // Months shown.
        logic [7:0] pressure;                    // Back pressure shown.
    } dpl_disp_type;

endpackage : dpl_pkg

// [src/dpl_pin_sync.sv]
/*
  Three-stage synchroniser for one pin with level agreement and edge pulses.
  Assumes the pin is asynchronous to sys_clk_i and bounces no faster than
  two clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module dpl_pin_sync (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Pin side
    input wire logic pin_i,
    // Clean side
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    // ------------------------------------------------------------------
    // Sampling chain
    // ------------------------------------------------------------------
    logic s1_r;  // First stage, read only by the second.
    logic s2_r;  // Second stage.
    logic s3_r;  // Third stage.

    // The level only moves once the second and third stages agree, so a
    // single metastable sample cannot produce a false edge.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Agreed level and one-cycle edge pulses.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            level_o <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            if (s2_r == s3_r && s3_r != level_o) begin
                level_o <= s3_r;
                rise_o <= s3_r;
                fall_o <= !s3_r;
            end
        end
    end

endmodule : dpl_pin_sync
`default_nettype wire

// [src/dpl_scheduler.sv]
/*
  Drain-period lubrication scheduler with its single-key settings menu.
  Assumes a 50 MHz clock, a key sensor pin asynchronous to it, and status
  and pressure inputs produced by logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dpl_scheduler import dpl_pkg::*; #(
    parameter int TICK_DIV = TICK_CYCLES,        // Clock cycles per ms tick.
    parameter int TICKS_PER_S = MS_PER_S,        // Ticks per second.
    parameter int STROKE_TIME_S = STROKE_S,      // Stroke time, at most 17.
    parameter int AUTO_FIRST = AUTO_FIRST_MS,    // First auto step, ms.
    parameter int AUTO_MIN = AUTO_MIN_MS,        // Fastest auto step, ms.
    parameter int AUTO_DEC = AUTO_DEC_MS         // Step shortening, ms.
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Key sensor pin
    input wire logic key_i,
    // Device status
    input wire logic switched_on_i,
    input wire logic fault_i,
    input wire logic supply_ok_i,
    input wire logic cartridge_i,
    input wire logic drain_mode_i,
    input wire logic large_cart_i,
    input wire logic [7:0] pressure_i,
    // Pump control
    output logic pump_burst_o,
    output logic relax_o,
    output logic cycle_restart_o,
    // Settings and display
    output logic [5:0] drain_period_months_o,
    output logic [7:0] burst_interval_hours_o,
    output logic menu_active_o,
    output dpl_disp_type disp_o
);

    // ------------------------------------------------------------------
    // Key synchroniser
    // ------------------------------------------------------------------
    logic key_on;    // Key present on the action area.
    logic key_rise;  // Key just arrived.
    logic key_fall;  // Key just left.

    dpl_pin_sync u_key_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pin_i(key_i),
        .level_o(key_on),
        .rise_o(key_rise),
        .fall_o(key_fall)
    );

    // ------------------------------------------------------------------
    // Time base: millisecond and second enables
    // ------------------------------------------------------------------
    logic [15:0] div_r;   // Clock cycles within one ms.
    logic [9:0] ms_cnt_r; // Milliseconds within one second.
    logic ms_tick;        // One-cycle ms enable.
    logic s_tick;         // One-cycle second enable.

    assign ms_tick = (div_r == 16'(TICK_DIV - 1));
    assign s_tick = ms_tick && (ms_cnt_r == 10'(TICKS_PER_S - 1));

    // Free-running dividers; the scheduler never stops the time base.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            div_r <= 16'h0000;
            ms_cnt_r <= 10'h000;
        end else if (ms_tick) begin
            div_r <= 16'h0000;
            ms_cnt_r <= s_tick ? 10'h000 : ms_cnt_r + 10'h001;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Drain period and derived interval
    // ------------------------------------------------------------------
    logic [5:0] drain_r;     // Active drain period in months.
    logic [5:0] cand_r;      // Candidate shown while editing.
    logic [27:0] strokes;    // Strokes per cartridge.
    logic [19:0] interval_s; // Interval between bursts in seconds.
    logic [19:0] pause_s;    // Pause after the burst in seconds.
    logic [7:0] hours;       // Interval in whole hours, rounded down.
    logic [27:0] prod_s;     // Months times seconds per month.
    logic [15:0] prod_h;     // Months times hours per month.

    // Interval = months * 30.5 d * 24 h / strokes per cartridge.
    always_comb begin
        strokes = large_cart_i ? STROKES_LARGE : STROKES_SMALL;
        prod_s = 28'(drain_r) * SEC_PER_MONTH;
        prod_h = 16'(drain_r) * HOURS_PER_MONTH;
        interval_s = 20'(prod_s / strokes);
        hours = 8'(28'(prod_h) / strokes);
        pause_s = interval_s - 20'(STROKE_TIME_S);
    end

    // Next value while stepping, wrapping past the top of the range.
    function automatic logic [5:0] step_up(input logic [5:0] v);
        if (v >= DRAIN_MAX) begin
            step_up = DRAIN_MIN;
        end else begin
            step_up = v + 6'h01;
        end
    endfunction : step_up

    // ------------------------------------------------------------------
    // Menu state machine
    // ------------------------------------------------------------------
    dpl_state_type state_r;
    dpl_state_type state_nxt;
    logic [15:0] tmr_r;      // Milliseconds spent in the state or step.
    logic [15:0] step_r;     // Current auto-advance step length.
    logic [2:0] flash_r;     // Flash half periods done.
    logic flash_done;        // Both flashes finished.
    logic advance;           // Candidate moves up by one.
    logic commit;            // Candidate becomes the drain period.
    logic allowed;           // Menu may run at all.

    assign flash_done = (flash_r == 3'(FLASH_PHASES));
    assign allowed = switched_on_i && !fault_i;

    // Next state and the one-cycle actions that go with it.
    always_comb begin
        state_nxt = state_r;
        advance = 1'b0;
        commit = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (key_rise && allowed) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!key_on) begin
                    state_nxt = ST_IDLE;
                end else if (tmr_r >= 16'(ENTER_HOLD_MS)) begin
                    state_nxt = ST_LABEL;
                end
            end
            ST_LABEL: begin
                if (key_fall) begin
                    state_nxt = ST_ENTRY_OK;
                end
            end
            ST_ENTRY_OK: begin
                if (flash_done) begin
                    state_nxt = ST_SHOW_MODE;
                end
            end
            ST_SHOW_MODE: begin
                // Other modes are not edited here; leave straight away.
                if (flash_done) begin
                    state_nxt = drain_mode_i ? ST_SHOW_VAL : ST_IDLE;
                end
            end
            ST_SHOW_VAL: begin
                if (key_rise) begin
                    state_nxt = ST_EDIT;
                    advance = 1'b1;
                end else if (tmr_r >= 16'(DECIDE_MS)) begin
                    state_nxt = ST_KEEP_OK;
                end
            end
            ST_EDIT: begin
                if (key_fall) begin
                    state_nxt = ST_GAP;
                end else if (tmr_r >= step_r) begin
                    advance = 1'b1;
                end
            end
            ST_GAP: begin
                if (key_rise) begin
                    state_nxt = ST_EDIT;
                    advance = 1'b1;
                end else if (tmr_r >= 16'(REPLACE_GAP_MS)) begin
                    state_nxt = ST_COMMIT_OK;
                    commit = 1'b1;
                end
            end
            ST_COMMIT_OK, ST_KEEP_OK: begin
                if (flash_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Switching off or a fault abandons the menu without a commit.
        if (!allowed && state_r != ST_IDLE) begin
            state_nxt = ST_IDLE;
            commit = 1'b0;
            advance = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Millisecond timer, restarted on every state change and every step.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            tmr_r <= 16'h0000;
        end else if (state_nxt != state_r || advance) begin
            tmr_r <= 16'h0000;
        end else if (ms_tick && tmr_r != 16'hFFFF) begin
            tmr_r <= tmr_r + 16'h0001;
        end
    end

    // Flash counter for the twofold confirmation flash.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            flash_r <= 3'h0;
        end else if (state_nxt != state_r) begin
            flash_r <= 3'h0;
        end else if (ms_tick && !flash_done && tmr_r >= 16'(FLASH_HALF_MS) * 16'(flash_r + 3'h1)) begin
            flash_r <= flash_r + 3'h1;
        end
    end

    // Auto-advance step: starts slow and shortens with each value, so a
    // long hold crosses the range quickly yet the first values are easy
    // to catch.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            step_r <= 16'(AUTO_FIRST);
        end else if (state_r != ST_EDIT) begin
            step_r <= 16'(AUTO_FIRST);
        end else if (advance && step_r >= 16'(AUTO_MIN + AUTO_DEC)) begin
            step_r <= step_r - 16'(AUTO_DEC);
        end
    end

    // Candidate value, seeded from the active period on the first step up from the value display.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cand_r <= DRAIN_RESET;
        end else if (advance) begin
            cand_r <= step_up(state_r == ST_SHOW_VAL ? drain_r : cand_r);
        end
    end

    // Active drain period; only whole months in range are ever stored.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            drain_r <= DRAIN_RESET;
        end else if (commit && cand_r >= DRAIN_MIN && cand_r <= DRAIN_MAX) begin
            drain_r <= cand_r;
        end
    end

    // ------------------------------------------------------------------
    // Burst and pause sequencer
    // ------------------------------------------------------------------
    logic [19:0] sec_r;   // Seconds since the current burst began.
    logic run_ok;         // Ready to lubricate.
    logic restart;        // Start a fresh lubrication cycle now.
    logic in_stroke;      // Within the single stroke.
    logic in_relax;       // Within the relaxation time.

    assign run_ok = switched_on_i && !fault_i && supply_ok_i && cartridge_i;
    assign restart = commit && supply_ok_i && cartridge_i;
    assign in_stroke = (sec_r < 20'(STROKE_TIME_S));
    assign in_relax = !in_stroke && (sec_r < 20'(STROKE_TIME_S + RELAX_S));

    // The cycle is one stroke followed by the pause; the relaxation time
    // is spent inside the pause. A restart drops any burst in progress.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sec_r <= 20'h00000;
        end else if (restart) begin
            sec_r <= 20'h00000;
        end else if (run_ok && s_tick) begin
            if (sec_r >= 20'(STROKE_TIME_S) + pause_s - 20'h00001) begin
                sec_r <= 20'h00000;
            end else begin
                sec_r <= sec_r + 20'h00001;
            end
        end
    end

    // Pump outputs, registered and held off whenever not ready.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pump_burst_o <= 1'b0;
            relax_o <= 1'b0;
            cycle_restart_o <= 1'b0;
        end else begin
            pump_burst_o <= run_ok && !restart && in_stroke;
            relax_o <= run_ok && !restart && in_relax;
            cycle_restart_o <= restart;
        end
    end

    // ------------------------------------------------------------------
    // Back pressure per stroke
    // ------------------------------------------------------------------
    logic [7:0] press_r;  // Latest pressure of the running stroke.

    // Sampled each ms during the stroke and held through the relaxation,
    // so each stroke shows its own reading.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            press_r <= 8'h00;
        end else if (pump_burst_o && ms_tick) begin
            press_r <= pressure_i;
        end
    end

    // ------------------------------------------------------------------
    // Display and status outputs
    // ------------------------------------------------------------------
    dpl_disp_type disp_nxt;
    logic confirming;     // A flash sequence is running.

    assign confirming = (state_r == ST_ENTRY_OK) || (state_r == ST_SHOW_MODE)
        || (state_r == ST_COMMIT_OK) || (state_r == ST_KEEP_OK);

    // Display contents as a function of the menu state.
    always_comb begin
        disp_nxt = '0;
        disp_nxt.value = drain_r;
        disp_nxt.pressure = press_r;
        disp_nxt.dbl_circle = key_on && (state_r == ST_HOLD || state_r == ST_LABEL
            || state_r == ST_EDIT);
        disp_nxt.settings_label = (state_r == ST_LABEL);
        disp_nxt.mode_icon = (state_r == ST_SHOW_MODE);
        disp_nxt.hook = confirming;
        disp_nxt.blank = confirming && flash_r[0];
        if (state_r == ST_EDIT || state_r == ST_GAP || state_r == ST_COMMIT_OK) begin
            disp_nxt.value = cand_r;
        end
        if (state_r == ST_IDLE && (pump_burst_o || relax_o)) begin
            disp_nxt.show_pressure = 1'b1;
        end
    end

    // Registered outputs.
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            disp_o <= '0;
            drain_period_months_o <= DRAIN_RESET;
            burst_interval_hours_o <= 8'h00;
            menu_active_o <= 1'b0;
        end else begin
            disp_o <= disp_nxt;
            drain_period_months_o <= drain_r;
            burst_interval_hours_o <= hours;
            menu_active_o <= (state_nxt != ST_IDLE);
        end
    end

endmodule : dpl_scheduler
`default_nettype wire

// [sim/dpl_scheduler_properties.sv]
/* Checker of the drain-period scheduler, seeing only its ports.
   Assumes it is bound to dpl_scheduler, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module dpl_scheduler_properties import dpl_pkg::*; (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Status inputs
    input wire logic switched_on_i,
    input wire logic fault_i,
    input wire logic supply_ok_i,
    input wire logic cartridge_i,
    input wire logic large_cart_i,
    // Watched outputs
    input wire logic pump_burst_o,
    input wire logic relax_o,
    input wire logic cycle_restart_o,
    input wire logic [5:0] drain_period_months_o,
    input wire logic [7:0] burst_interval_hours_o,
    input wire logic menu_active_o,
    input wire dpl_disp_type disp_o
);
    // A stroke may only end on its own while the pump is free to run.
    wire logic run_w = switched_on_i && supply_ok_i && cartridge_i && !fault_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    drain_in_range_a: assert property (
        drain_period_months_o inside {[6'h01:6'h24]}) else $error("drain period out of range");
    reset_default_a: assert property (
        !$past(nrst_i) |-> drain_period_months_o == 6'h06) else $error("drain period not 6 after reset");
    step_by_one_a: assert property (
        $changed(disp_o.value) && disp_o.dbl_circle && $past(disp_o.dbl_circle) |-> disp_o.value ==
        (($past(disp_o.value) == 6'h24) ? 6'h01 : $past(disp_o.value) + 6'h01)) else $error("bad step");
    hours_match_a: assert property (
        $stable(drain_period_months_o) && $stable(large_cart_i) ##1 $stable(drain_period_months_o) &&
        $stable(large_cart_i) |-> burst_interval_hours_o == 8'((32'(drain_period_months_o) * 732) /
        (large_cart_i ? 1560 : 780))) else $error("interval hours wrong");
    burst_then_relax_a: assert property (
        $fell(pump_burst_o) && run_w && $past(run_w) && !cycle_restart_o |-> relax_o)
        else $error("no relaxation after stroke");
    restart_ready_a: assert property (
        cycle_restart_o |-> $past(supply_ok_i && cartridge_i)) else $error("restart while not ready");
    restart_pumps_a: assert property (
        cycle_restart_o && run_w |-> ##[1:2] pump_burst_o && !relax_o) else $error("no burst on restart");
    entry_refused_a: assert property (
        !switched_on_i || fault_i |=> !menu_active_o) else $error("menu active while off or faulted");
endmodule : dpl_scheduler_properties
bind dpl_scheduler dpl_scheduler_properties i_dpl_scheduler_properties (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .switched_on_i(switched_on_i), .fault_i(fault_i), .supply_ok_i(supply_ok_i),
    .cartridge_i(cartridge_i), .large_cart_i(large_cart_i), .pump_burst_o(pump_burst_o),
    .relax_o(relax_o), .cycle_restart_o(cycle_restart_o), .drain_period_months_o(drain_period_months_o),
    .burst_interval_hours_o(burst_interval_hours_o), .menu_active_o(menu_active_o), .disp_o(disp_o));
`default_nettype wire

// [sim/dpl_key_operator.sv]
/* Operator model: places the magnetic key on the action area or lifts it.
   Assumes the bench calls put_key just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module dpl_key_operator (
    // Key sensor pin
    output logic key_o
);
    initial key_o = 1'b0;
    // The key stays where it was put; brief lifts and long absences come from the caller.
    task automatic put_key(input logic on);
        key_o = on;
    endtask : put_key
endmodule : dpl_key_operator
`default_nettype wire

// [sim/dpl_scheduler_test.sv]
/* Self-checking bench of the drain-period scheduler.
   Assumes a shortened time base: 4 cycles a ms, 4 ms a second, 3 s stroke. */
`timescale 1ns/1ps
`default_nettype none
module dpl_scheduler_test import dpl_pkg::*;;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, key_w, switched_on_i = 1'b1, fault_i = 1'b0;
    logic supply_ok_i = 1'b1, cartridge_i = 1'b1, drain_mode_i = 1'b1, large_cart_i = 1'b0;
    logic [7:0] pressure_i = 8'h5A, hours_w;
    logic pump_w, relax_w, restart_w, menu_w;
    logic [5:0] drain_w;
    dpl_disp_type disp_w;
    int num_errors = 0, checks_done = 0, cycles = 0;
    dpl_key_operator i_dpl_key_operator (.key_o(key_w));
    // The auto-advance steps are shortened too, so a full wrap of the range fits in the run.
    dpl_scheduler #(.TICK_DIV(4), .TICKS_PER_S(4), .STROKE_TIME_S(3), .AUTO_FIRST(12), .AUTO_MIN(4),
        .AUTO_DEC(2)) i_dpl_scheduler (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .key_i(key_w), .switched_on_i(switched_on_i),
        .fault_i(fault_i), .supply_ok_i(supply_ok_i), .cartridge_i(cartridge_i),
        .drain_mode_i(drain_mode_i), .large_cart_i(large_cart_i), .pressure_i(pressure_i),
        .pump_burst_o(pump_w), .relax_o(relax_w), .cycle_restart_o(restart_w),
        .drain_period_months_o(drain_w), .burst_interval_hours_o(hours_w), .menu_active_o(menu_w),
        .disp_o(disp_w));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    // A hang ends the run as a failure instead of running on.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 99000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // Hold the key until the label shows, lift it, and stop on the value display, or in idle for another mode.
    task automatic enter_menu(input logic [5:0] exp_val);
        i_dpl_key_operator.put_key(1'b1);
        for (int i = 0; i < 13000 && disp_w.settings_label !== 1'b1; i++) tick(1);
        chk(8'(disp_w.dbl_circle), 8'h01);
        i_dpl_key_operator.put_key(1'b0);
        tick(4100);
        chk(8'(disp_w.mode_icon), 8'h01);
        tick(4200);
        chk(8'(disp_w.value), 8'(exp_val));
        chk(8'(menu_w), 8'(drain_mode_i));
    endtask : enter_menu
    initial begin
        tick(20);
        nrst_i = 1'b1;
        tick(2);
        chk(8'(drain_w), 8'h06);
        chk(hours_w, 8'h05);
        chk(8'(pump_w), 8'h01);
        large_cart_i = 1'b1;
        tick(26);
        chk(hours_w, 8'h02);
        chk(disp_w.pressure, 8'h5A);
        chk(8'(disp_w.show_pressure), 8'h01);
        tick(26);
        chk(8'({relax_w, pump_w}), 8'h02);
        // Losing supply or cartridge silences the pump; restoring them resumes the relaxation.
        for (int i = 0; i < 4; i++) begin
            {supply_ok_i, cartridge_i} = (i == 0) ? 2'b01 : ((i == 2) ? 2'b10 : 2'b11);
            tick(2);
            chk(8'({relax_w, pump_w}), (i % 2 == 0) ? 8'h00 : 8'h02);
        end
        for (int i = 0; i < 2; i++) begin
            fault_i = (i == 0);
            switched_on_i = (i == 0);
            i_dpl_key_operator.put_key(1'b1);
            tick(50);
            chk(8'(menu_w), 8'h00);
            i_dpl_key_operator.put_key(1'b0);
            tick(10);
        end
        fault_i = 1'b0;
        switched_on_i = 1'b1;
        enter_menu(6'h06);
        pressure_i = 8'hA7;
        i_dpl_key_operator.put_key(1'b1);
        tick(20);
        chk(8'(disp_w.value), 8'h07);
        i_dpl_key_operator.put_key(1'b0);
        tick(100);
        i_dpl_key_operator.put_key(1'b1);
        tick(20);
        chk(8'(disp_w.value), 8'h08);
        // A held key runs on through 36, wraps to 01, and is released on 03.
        for (int i = 0; i < 1000 && disp_w.value !== 6'h01; i++) tick(1);
        chk(8'(disp_w.value), 8'h01);
        for (int i = 0; i < 200 && disp_w.value !== 6'h03; i++) tick(1);
        chk(8'({disp_w.dbl_circle, disp_w.value}), 8'h43);
        i_dpl_key_operator.put_key(1'b0);
        for (int i = 0; i < 4500 && restart_w !== 1'b1; i++) tick(1);
        chk(8'(restart_w), 8'h01);
        tick(2);
        chk(8'(drain_w), 8'h03);
        chk(hours_w, 8'h01);
        chk(8'({disp_w.hook, pump_w}), 8'h03);
        tick(4200);
        chk(8'(menu_w), 8'h00);
        chk(disp_w.pressure, 8'hA7);
        // Another mode only shows itself and returns to idle.
        drain_mode_i = 1'b0;
        enter_menu(6'h03);
        drain_mode_i = 1'b1;
        enter_menu(6'h03);
        tick(20100);
        chk(8'({disp_w.hook, drain_w}), 8'h43);
        final_report();
    end
endmodule : dpl_scheduler_test
`default_nettype wire
